// File: hdl/bpst_top.sv
/*
 * Burst preamble status block: parses burst headers out of the decoded
 * non-PCM word stream, holds the last burst-info and burst-length words
 * as read-only byte registers and decodes the data type.
 * Assumes a byte-wide register port behind the serial control interface
 * and a word stream from receiver logic on sys_clk.
 */
// What this block does
// (R1) Offset 0x29 reads burst-info bits 15 to 8, bit 15 at the top.
// (R2) Offset 0x2a reads burst-info bits 7 to 0, bit 7 at the top.
// (R3) Offset 0x2b reads burst-length bits 15 to 8, bit 15 at the top.
// (R4) Offset 0x2c reads burst-length bits 7 to 0, bit 7 at the top.
// (R5) Info bits 4 to 0 give the data type: null, pause, reserved or a format.
// (R6) Info bits 6 and 5 always read as zero.
// (R7) Info bit 7 is set when the burst payload may contain errors.
// (R8) Info bits 12 to 8 are reported as decoded, uninterpreted.
// (R9) Info bits 15 to 13 report the stream number.
// (R10) The burst-length word gives the burst length in bits.
// (R11) A burst is found by sync words 0xf872 then 0x4e1f before info, length.
// (R12) The status updates per decoded header, holds, and ignores writes.
`timescale 1ns/1ps
module bpst_top
    import bpst_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Decoded word stream from the receiver.
    input  wire logic        word_valid,
    input  wire logic [15:0] word_data,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    // Burst status.
    output logic             burst_update,
    output logic [4:0]       burst_type,
    output logic             burst_error,
    output logic [2:0]       burst_stream,
    output logic             type_null,
    output logic             type_pause,
    output logic             type_reserved,
    // Converter control fields.
    output logic [1:0]       converter_input_select,
    output logic [1:0]       converter_clock_select,
    output logic             converter_mute,
    output logic             converter_track
);
    import bpst_pkg::*;

    logic        header_valid;
    logic [15:0] header_info;
    logic [15:0] header_length;
    logic [15:0] burst_info_word;
    logic [15:0] next_burst_info_word;
    logic [15:0] burst_length_word;
    logic [15:0] next_burst_length_word;
    logic [7:0]  conv_ctrl;
    logic [7:0]  next_conv_ctrl;
    logic        update;
    logic        next_update;
    logic        next_null;
    logic        next_pause;
    logic        next_reserved;

    // True for the data type codes that are reserved.
    function automatic logic bpst_is_reserved(input logic [4:0] code);
        bpst_is_reserved = (code == BPST_TYPE_RES_A) ||
                           (code == BPST_TYPE_RES_B) ||
                           (code >= BPST_TYPE_RES_C);
    endfunction : bpst_is_reserved

    // Finds each burst header in the word stream.
    bpst_sync_detect u_sync (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .word_valid    (word_valid),
        .word_data     (word_data),
        .header_valid  (header_valid),
        .header_info   (header_info),
        .header_length (header_length)
    );

    // Takes both words together on a header, else holds; writes ignored.
    always_comb begin
        next_burst_info_word   = burst_info_word;
        next_burst_length_word = burst_length_word;
        next_update            = 1'b0;
        if (header_valid) begin // R12
            next_burst_info_word   = header_info & BPST_INFO_MASK; // R6 R8 R9
            next_burst_length_word = header_length; // R10
            next_update            = 1'b1;
        end
    end

    // Writable converter control; status offsets are read-only.
    always_comb begin
        next_conv_ctrl = conv_ctrl;
        if (reg_wr && (reg_addr == BPST_OFF_CONV)) begin
            next_conv_ctrl = reg_wdata & BPST_CONV_MASK;
        end
    end

    // Type decode of the stored info word.
    always_comb begin
        next_null     = burst_type == BPST_TYPE_NULL;   // R5
        next_pause    = burst_type == BPST_TYPE_PAUSE;  // R5
        next_reserved = bpst_is_reserved(burst_type);   // R5
    end

    // Registers the status words, control and decoded flags.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            burst_info_word   <= BPST_RST_WORD;
            burst_length_word <= BPST_RST_WORD;
            conv_ctrl         <= BPST_RST_CONV;
            update            <= 1'b0;
            type_null         <= 1'b0;
            type_pause        <= 1'b0;
            type_reserved     <= 1'b0;
        end else begin
            burst_info_word   <= next_burst_info_word;
            burst_length_word <= next_burst_length_word;
            conv_ctrl         <= next_conv_ctrl;
            update            <= next_update;
            type_null         <= next_null;
            type_pause        <= next_pause;
            type_reserved     <= next_reserved;
        end
    end

    // Field views of the stored words and control register.
    assign burst_type   = burst_info_word[BPST_TYPE_MSB:BPST_TYPE_LSB]; // R5
    assign burst_error  = burst_info_word[BPST_ERR_BIT]; // R7
    assign burst_stream =
        burst_info_word[BPST_STREAM_MSB:BPST_STREAM_LSB]; // R9
    assign burst_update = update;
    assign converter_input_select =
        conv_ctrl[BPST_CONV_IS_LSB+1:BPST_CONV_IS_LSB];
    assign converter_clock_select =
        conv_ctrl[BPST_CONV_CLK_LSB+1:BPST_CONV_CLK_LSB];
    assign converter_mute  = conv_ctrl[BPST_CONV_MUTE];
    assign converter_track = conv_ctrl[BPST_CONV_TRACK];

    // Registered read path.
    bpst_reg_read u_read (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .reg_rd      (reg_rd),
        .reg_addr    (reg_addr),
        .info_word   (burst_info_word),
        .length_word (burst_length_word),
        .conv_value  (conv_ctrl),
        .reg_rdata   (reg_rdata),
        .reg_rvalid  (reg_rvalid)
    );

endmodule : bpst_top

// File: include/bpst_pkg.sv
/*
 * Shared constants for the burst preamble status block: register offsets,
 * reset values, field positions, sync words and data type codes.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package bpst_pkg;

    // Register offsets on the byte-wide control port.
    localparam logic [7:0] BPST_OFF_INFO_HI = 8'h29;
    localparam logic [7:0] BPST_OFF_INFO_LO = 8'h2a;
    localparam logic [7:0] BPST_OFF_LEN_HI  = 8'h2b;
    localparam logic [7:0] BPST_OFF_LEN_LO  = 8'h2c;
    localparam logic [7:0] BPST_OFF_CONV    = 8'h2d;

    // Values after reset.
    localparam logic [15:0] BPST_RST_WORD = 16'h0000;
    localparam logic [7:0]  BPST_RST_CONV = 8'h00;
    localparam logic [7:0]  BPST_RST_DATA = 8'h00;

    // Fixed synchronisation words that open every burst.
    localparam logic [15:0] BPST_SYNC_A = 16'hf872;
    localparam logic [15:0] BPST_SYNC_B = 16'h4e1f;

    // Field positions inside the burst-info word.
    localparam int BPST_TYPE_LSB   = 0;
    localparam int BPST_TYPE_MSB   = 4;
    localparam int BPST_ZERO_LSB   = 5;
    localparam int BPST_ZERO_MSB   = 6;
    localparam int BPST_ERR_BIT    = 7;
    localparam int BPST_DEP_LSB    = 8;
    localparam int BPST_DEP_MSB    = 12;
    localparam int BPST_STREAM_LSB = 13;
    localparam int BPST_STREAM_MSB = 15;

    // Mask that clears the two always-zero bits of the info word.
    localparam logic [15:0] BPST_INFO_MASK = 16'hff9f;

    // Data type codes with a fixed meaning.
    localparam logic [4:0] BPST_TYPE_NULL  = 5'h00;
    localparam logic [4:0] BPST_TYPE_RES_A = 5'h02;
    localparam logic [4:0] BPST_TYPE_PAUSE = 5'h03;
    localparam logic [4:0] BPST_TYPE_RES_B = 5'h0a;
    localparam logic [4:0] BPST_TYPE_RES_C = 5'h10;

    // Field positions in the converter control register.
    localparam int BPST_CONV_IS_LSB  = 0;
    localparam int BPST_CONV_CLK_LSB = 2;
    localparam int BPST_CONV_MUTE    = 4;
    localparam int BPST_CONV_TRACK   = 6;
    localparam logic [7:0] BPST_CONV_MASK = 8'h5f;

    // Header parser states.
    typedef enum logic [1:0] {
        BPST_SEEK_A,
        BPST_SEEK_B,
        BPST_GET_INFO,
        BPST_GET_LEN
    } bpst_state_t;

endpackage : bpst_pkg

// File: hdl/bpst_sync_detect.sv
/*
 * Burst header parser: finds the two sync words in the decoded word stream
 * and hands out the burst-info and burst-length words that follow them.
 * Assumes the word stream comes from logic on sys_clk.
 */
`timescale 1ns/1ps
module bpst_sync_detect
    import bpst_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Decoded word stream.
    input  wire logic        word_valid,
    input  wire logic [15:0] word_data,
    // Parsed header.
    output logic             header_valid,
    output logic [15:0]      header_info,
    output logic [15:0]      header_length
);
    import bpst_pkg::*;

    bpst_state_t state;
    bpst_state_t next_state;
    logic [15:0] info;
    logic [15:0] next_info;
    logic [15:0] length;
    logic [15:0] next_length;
    logic        done;
    logic        next_done;

    // Walks sync A, sync B, info, length; a mismatch restarts the search.
    always_comb begin
        next_state  = state;
        next_info   = info;
        next_length = length;
        next_done   = 1'b0;
        if (word_valid) begin
            case (state)
                BPST_SEEK_A: begin
                    if (word_data == BPST_SYNC_A) begin // R11
                        next_state = BPST_SEEK_B;
                    end
                end
                BPST_SEEK_B: begin
                    if (word_data == BPST_SYNC_B) begin // R11
                        next_state = BPST_GET_INFO;
                    end else if (word_data == BPST_SYNC_A) begin
                        next_state = BPST_SEEK_B;
                    end else begin
                        next_state = BPST_SEEK_A;
                    end
                end
                BPST_GET_INFO: begin
                    next_info  = word_data;
                    next_state = BPST_GET_LEN;
                end
                BPST_GET_LEN: begin
                    next_length = word_data; // R10
                    next_done   = 1'b1;
                    next_state  = BPST_SEEK_A;
                end
                default: begin
                    next_state = BPST_SEEK_A;
                end
            endcase
        end
    end

    // Registers the parser state.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state  <= BPST_SEEK_A;
            info   <= BPST_RST_WORD;
            length <= BPST_RST_WORD;
            done   <= 1'b0;
        end else begin
            state  <= next_state;
            info   <= next_info;
            length <= next_length;
            done   <= next_done;
        end
    end

    assign header_valid  = done;
    assign header_info   = info;
    assign header_length = length;

endmodule : bpst_sync_detect

// File: hdl/bpst_reg_read.sv
/*
 * Read multiplexer for the status and control registers; the read data
 * come out of a register one cycle after the read strobe.
 * Assumes the read strobe comes from logic on sys_clk.
 */
`timescale 1ns/1ps
module bpst_reg_read
    import bpst_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Read request.
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    // Register contents.
    input  wire logic [15:0] info_word,
    input  wire logic [15:0] length_word,
    input  wire logic [7:0]  conv_value,
    // Read answer.
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid
);
    import bpst_pkg::*;

    logic [7:0] next_rdata;

    // Selects the byte at an offset; unmapped offsets read as zero.
    function automatic logic [7:0] bpst_pick(input logic [7:0]  addr,
                                             input logic [15:0] info,
                                             input logic [15:0] len,
                                             input logic [7:0]  conv);
        case (addr)
            BPST_OFF_INFO_HI: bpst_pick = info[15:8]; // R1
            BPST_OFF_INFO_LO: bpst_pick = info[7:0];  // R2
            BPST_OFF_LEN_HI:  bpst_pick = len[15:8];  // R3
            BPST_OFF_LEN_LO:  bpst_pick = len[7:0];   // R4
            BPST_OFF_CONV:    bpst_pick = conv;
            default:          bpst_pick = BPST_RST_DATA;
        endcase
    endfunction : bpst_pick

    // Loads the answer only on a read, so it stands until the next one.
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            next_rdata = bpst_pick(reg_addr, info_word, length_word,
                                   conv_value);
        end
    end

    // Registers the answer.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata  <= BPST_RST_DATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= reg_rd;
        end
    end

endmodule : bpst_reg_read

// File: tb/bpst_top_chk.sv
/*
 * Concurrent checks on the ports of bpst_top.
 * Assumes it is bound to bpst_top from the testbench top file.
 */
`timescale 1ns/1ps
module bpst_top_chk
    import bpst_pkg::*;
(
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       reset,
    // Word stream.
    input wire logic       word_valid,
    input wire logic [15:0] word_data,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // Status and control outputs.
    input wire logic       burst_update,
    input wire logic [4:0] burst_type,
    input wire logic       burst_error,
    input wire logic [2:0] burst_stream,
    input wire logic       type_null,
    input wire logic       type_pause,
    input wire logic       type_reserved,
    input wire logic [1:0] converter_input_select,
    input wire logic [1:0] converter_clock_select,
    input wire logic       converter_mute,
    input wire logic       converter_track
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // A read is answered exactly one cycle later, and only then.
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    a_no_stray_rvalid: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without a read");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_info_zero_bits: assert property (reg_rd &&
        reg_addr == BPST_OFF_INFO_LO |=> reg_rdata[6:5] == 2'b00)
        else $error("info bits 6 and 5 not zero");

    // Status moves only with an update pulse.
    a_status_holds: assert property (!burst_update |->
        $stable({burst_type, burst_error, burst_stream}))
        else $error("status changed without update");

    // A gapless header gives an update two cycles after its length word.
    a_header_update: assert property (
        word_valid && word_data == BPST_SYNC_A ##1
        word_valid && word_data == BPST_SYNC_B ##1
        word_valid ##1 word_valid |-> ##2 burst_update)
        else $error("header did not update status");

    // Type flags follow the stored type one cycle after the update.
    a_null_flag: assert property (burst_update |=>
        type_null == ($past(burst_type) == BPST_TYPE_NULL))
        else $error("null flag wrong");
    a_pause_flag: assert property (burst_update |=>
        type_pause == ($past(burst_type) == BPST_TYPE_PAUSE))
        else $error("pause flag wrong");
    a_reserved_flag: assert property (burst_update |=>
        type_reserved == (burst_type inside {5'h02, 5'h0a} ||
        burst_type[4]))
        else $error("reserved flag wrong");

    // Writes elsewhere leave the control fields alone.
    a_write_ignored: assert property (reg_wr &&
        reg_addr != BPST_OFF_CONV |=> $stable({converter_input_select,
        converter_clock_select, converter_mute, converter_track}))
        else $error("control changed by stray write");

    // Main scenarios reached.
    c_update: cover property (burst_update);
    c_reserved: cover property (type_reserved);
    c_conv_read: cover property (reg_rd && reg_addr == BPST_OFF_CONV);
endmodule : bpst_top_chk

// File: tb/bpst_top_tb.sv
/*
 * Random self-checking bench for bpst_top.
 * Drives the word stream and register port itself; binds the checker.
 */
`timescale 1ns/1ps
module bpst_top_tb;
    import bpst_pkg::*;
    logic sys_clk, reset, word_valid, reg_rd, reg_wr, reg_rvalid;
    logic burst_update, burst_error, type_null, type_pause, type_reserved;
    logic converter_mute, converter_track;
    logic [1:0] converter_input_select, converter_clock_select;
    logic [15:0] word_data, info, len;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [7:0] eb [4];
    logic [4:0] burst_type;
    logic [2:0] burst_stream;
    int bad_count = 0;
    int comparisons = 0;

    bpst_top u_bpst_top (.sys_clk(sys_clk), .reset(reset),
        .word_valid(word_valid), .word_data(word_data),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .burst_update(burst_update),
        .burst_type(burst_type), .burst_error(burst_error),
        .burst_stream(burst_stream), .type_null(type_null),
        .type_pause(type_pause), .type_reserved(type_reserved),
        .converter_input_select(converter_input_select),
        .converter_clock_select(converter_clock_select),
        .converter_mute(converter_mute), .converter_track(converter_track));

    // Clock at 100 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    // Reserved data type codes.
    function automatic logic resv(input logic [4:0] t);
        return t == 5'h02 || t == 5'h0a || t[4];
    endfunction : resv

    // Sends one word, sometimes after an idle cycle.
    task automatic put(input logic [15:0] w);
        if ($urandom % 3 == 0) begin
            word_valid = 1'b0;
            tick();
        end
        word_valid = 1'b1;
        word_data = w;
        tick();
    endtask : put

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk("rvalid", 16'h1, {15'h0, reg_rvalid});
        d = reg_rdata;
        tick();
    endtask : rd

    task automatic wr(input logic [7:0] a, d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask : wr

    // Sends a whole header and checks status, flags and registers.
    task automatic hdr(input logic [15:0] i, l);
        logic [15:0] e;
        int n;
        e = i & ~16'h0060;
        eb = '{e[15:8], e[7:0], l[15:8], l[7:0]};
        put(BPST_SYNC_A);
        put(BPST_SYNC_B);
        put(i);
        put(l);
        word_valid = 1'b0;
        n = 0;
        while (burst_update !== 1'b1 && n < 6) begin
            tick();
            n++;
        end
        // The pulse stands one tick after the length word is taken.
        chk("update_lat", 16'd1, n[15:0]);
        chk("type", e[4:0], burst_type);
        chk("error", e[7], burst_error);
        chk("stream", e[15:13], burst_stream);
        tick();
        chk("null", e[4:0] == 5'h00, type_null);
        chk("pause", e[4:0] == 5'h03, type_pause);
        chk("reserved", resv(e[4:0]), type_reserved);
        for (int j = 0; j < 4; j++) begin
            rd(8'h29 + j[7:0], rv);
            chk("status_byte", eb[j], rv);
        end
    endtask : hdr

    task automatic results();
        $display("comparisons %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // Watchdog against a hung run.
    initial begin
        #200000;
        bad_count++;
        results();
    end

    // Main sequence.
    initial begin
        reset = 1'b1;
        word_valid = 1'b0;
        word_data = 16'h0000;
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        void'($urandom(32'h937e));
        repeat (3) @(posedge sys_clk);
        #1 reset = 1'b0;
        tick();
        for (int a = 8'h29; a <= 8'h2d; a++) begin
            rd(a[7:0], rv);
            chk("reset_val", 16'h0, rv);
        end
        for (int k = 0; k < 40; k++) begin
            info = $urandom;
            len = $urandom;
            info[4:0] = k[4:0];
            hdr(info, len);
        end
        for (int j = 0; j < 4; j++) begin
            wr(8'h29 + j[7:0], ~eb[j]);
            rd(8'h29 + j[7:0], rv);
            chk("ro_write", eb[j], rv);
        end
        wr(BPST_OFF_CONV, 8'hff);
        rd(BPST_OFF_CONV, rv);
        chk("conv", 16'h5f, rv);
        // All ones written, so every control field shows all ones.
        chk("conv_is", 16'h3, {14'h0, converter_input_select});
        chk("conv_clk", 16'h3, {14'h0, converter_clock_select});
        chk("conv_mute", 16'h1, {15'h0, converter_mute});
        chk("conv_track", 16'h1, {15'h0, converter_track});
        rd(8'h30, rv);
        chk("unmapped", 16'h0, rv);
        put(BPST_SYNC_A);
        hdr(16'hffff, 16'h0000);
        put(BPST_SYNC_A);
        put(16'h1234);
        put(BPST_SYNC_B);
        put(16'h5555);
        put(16'h6666);
        word_valid = 1'b0;
        repeat (4) begin
            tick();
            chk("no_update", 16'h0, burst_update);
        end
        rd(8'h2a, rv);
        chk("held", eb[1], rv);
        results();
    end
endmodule : bpst_top_tb

bind bpst_top bpst_top_chk u_bpst_top_chk (.sys_clk(sys_clk),
    .reset(reset), .word_valid(word_valid), .word_data(word_data),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .burst_update(burst_update), .burst_type(burst_type),
    .burst_error(burst_error), .burst_stream(burst_stream),
    .type_null(type_null), .type_pause(type_pause),
    .type_reserved(type_reserved),
    .converter_input_select(converter_input_select),
    .converter_clock_select(converter_clock_select),
    .converter_mute(converter_mute), .converter_track(converter_track));
